// ### hdl/tmie_pkg.sv
// constants for the two-wire master interrupt-enable register block
package tmie_pkg;

    // ----------------------------------------------------------------
    // register byte offsets
    // ----------------------------------------------------------------
    localparam logic [11:0] TMIE_OFS_DIRECT = 12'h300;
    localparam logic [11:0] TMIE_OFS_SET = 12'h304;
    localparam logic [11:0] TMIE_OFS_CLEAR = 12'h308;

    // ----------------------------------------------------------------
    // event enable fields: bit position in each register word
    // ----------------------------------------------------------------
    localparam int TMIE_NUM_EVENTS = 7;
    localparam int TMIE_BIT_STOPPED = 1;
    localparam int TMIE_BIT_ERROR = 9;
    localparam int TMIE_BIT_SUSPENDED = 18;
    localparam int TMIE_BIT_RECEIVE_BEGUN = 19;
    localparam int TMIE_BIT_TRANSMIT_BEGUN = 20;
    localparam int TMIE_BIT_FINAL_RECEIVE = 23;
    localparam int TMIE_BIT_FINAL_TRANSMIT = 24;

    // index of each event in the internal enable vector
    localparam int TMIE_IDX_STOPPED = 0;
    localparam int TMIE_IDX_ERROR = 1;
    localparam int TMIE_IDX_SUSPENDED = 2;
    localparam int TMIE_IDX_RECEIVE_BEGUN = 3;
    localparam int TMIE_IDX_TRANSMIT_BEGUN = 4;
    localparam int TMIE_IDX_FINAL_RECEIVE = 5;
    localparam int TMIE_IDX_FINAL_TRANSMIT = 6;

    // ----------------------------------------------------------------
    // reset values and bus answers
    // ----------------------------------------------------------------
    localparam logic [6:0] TMIE_ENABLE_RESET = 7'h00;
    localparam logic [31:0] TMIE_WORD_ZERO = 32'h0000_0000;
    localparam logic [1:0] TMIE_RESP_OKAY = 2'h0;
    localparam logic [1:0] TMIE_RESP_SLVERR = 2'h2;

    // which register a decoded address hits
    typedef enum logic [1:0] {
        TMIE_REG_NONE = 2'b00,
        TMIE_REG_DIRECT = 2'b01,
        TMIE_REG_SET = 2'b10,
        TMIE_REG_CLEAR = 2'b11
    } tmie_reg_t;

endpackage

// ### hdl/tmie_irq_enable.sv
// interrupt-enable set/clear register block of the two-wire bus master, AXI4-Lite slave
// Operation
// (RULE_01) writing one to a set-register field enables that event; reads return enables
// (RULE_02) writing one to a clear-register field disables that event; reads return enables
// (RULE_03) bus-error event has an enable bit, set and cleared via the two registers
// (RULE_04) transfer-suspended event has an enable bit, set or cleared by writing one
// (RULE_05) receive-begun event has a write-one-set and write-one-clear enable bit
// (RULE_06) transmit-begun event has a write-one-set and write-one-clear enable bit
// (RULE_07) final-receive-byte event has a write-one-set and write-one-clear enable bit
// (RULE_08) final-transmit-byte event has a write-one-set and write-one-clear enable bit
// (RULE_09) direct register reads and writes the same enables that set and clear modify
// (RULE_10) zero written to set or clear changes nothing; all enables reset disabled
// (RULE_11) interrupt output high while any pending event has its enable set; irq_out is registered and follows one cycle later
`timescale 1ns/1ns
`default_nettype none

module tmie_irq_enable
    import tmie_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rstn_in,
    // axi4-lite write address channel
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [ADDR_W-1:0] s_axi_awaddr_in,
    // axi4-lite write data channel
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    // axi4-lite write response channel
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    output logic [1:0] s_axi_bresp_out,
    // axi4-lite read address channel
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    input wire logic [ADDR_W-1:0] s_axi_araddr_in,
    // axi4-lite read data channel
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    // event pending levels from the bus master core, same clock
    input wire logic [TMIE_NUM_EVENTS-1:0] event_pending_in,
    // enable state and peripheral interrupt
    output logic [TMIE_NUM_EVENTS-1:0] irq_enable_out,
    output logic irq_out
);

    // ----------------------------------------------------------------
    // elaboration check
    // ----------------------------------------------------------------
    // the decode reads address bits eleven down to two, so twelve address bits are needed
    if (ADDR_W < 12) begin : g_bad_addr
        $error("ADDR_W must be at least 12");
    end

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // spread the internal enable vector onto its register word positions
    function automatic logic [31:0] pack_word(input logic [TMIE_NUM_EVENTS-1:0] en);
        logic [31:0] w;
        w = TMIE_WORD_ZERO;
        w[TMIE_BIT_STOPPED] = en[TMIE_IDX_STOPPED];
        w[TMIE_BIT_ERROR] = en[TMIE_IDX_ERROR];
        w[TMIE_BIT_SUSPENDED] = en[TMIE_IDX_SUSPENDED];
        w[TMIE_BIT_RECEIVE_BEGUN] = en[TMIE_IDX_RECEIVE_BEGUN];
        w[TMIE_BIT_TRANSMIT_BEGUN] = en[TMIE_IDX_TRANSMIT_BEGUN];
        w[TMIE_BIT_FINAL_RECEIVE] = en[TMIE_IDX_FINAL_RECEIVE];
        w[TMIE_BIT_FINAL_TRANSMIT] = en[TMIE_IDX_FINAL_TRANSMIT];
        return w;
    endfunction

    // gather the event fields of a register word into the internal vector
    function automatic logic [TMIE_NUM_EVENTS-1:0] unpack_word(input logic [31:0] w);
        logic [TMIE_NUM_EVENTS-1:0] en;
        en = TMIE_ENABLE_RESET;
        en[TMIE_IDX_STOPPED] = w[TMIE_BIT_STOPPED];
        en[TMIE_IDX_ERROR] = w[TMIE_BIT_ERROR];
        en[TMIE_IDX_SUSPENDED] = w[TMIE_BIT_SUSPENDED];
        en[TMIE_IDX_RECEIVE_BEGUN] = w[TMIE_BIT_RECEIVE_BEGUN];
        en[TMIE_IDX_TRANSMIT_BEGUN] = w[TMIE_BIT_TRANSMIT_BEGUN];
        en[TMIE_IDX_FINAL_RECEIVE] = w[TMIE_BIT_FINAL_RECEIVE];
        en[TMIE_IDX_FINAL_TRANSMIT] = w[TMIE_BIT_FINAL_TRANSMIT];
        return en;
    endfunction

    // word-aligned address decode; low two bits are ignored
    function automatic tmie_reg_t decode(input logic [ADDR_W-1:0] a);
        logic [11:0] wa;
        wa = {a[11:2], 2'b00};
        // a shift, not a part-select: the select would run backwards at the minimum width
        if ((a >> 12) != '0) begin
            return TMIE_REG_NONE;
        end
        case (wa)
            TMIE_OFS_DIRECT: return TMIE_REG_DIRECT;
            TMIE_OFS_SET: return TMIE_REG_SET;
            TMIE_OFS_CLEAR: return TMIE_REG_CLEAR;
            default: return TMIE_REG_NONE;
        endcase
    endfunction

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [TMIE_NUM_EVENTS-1:0] enable_r, enable_nxt;
    logic aw_held_r, w_held_r, bvalid_r, rvalid_r, irq_r;
    logic [ADDR_W-1:0] awaddr_r;
    logic [31:0] wdata_r, rdata_r;
    logic [3:0] wstrb_r;
    logic [1:0] bresp_r, rresp_r;

    // ----------------------------------------------------------------
    // write path decode
    // ----------------------------------------------------------------
    // address and data are caught separately so either may come first
    wire aw_take = s_axi_awvalid_in && !aw_held_r;
    wire w_take = s_axi_wvalid_in && !w_held_r;
    // commit only once the previous response has left, so bvalid never doubles up
    wire wr_go = aw_held_r && w_held_r && !bvalid_r;
    wire tmie_reg_t wr_sel = decode(awaddr_r);
    // byte enables widen to a bit mask; unstrobed lanes never touch an enable
    wire [31:0] strb_mask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
    wire [TMIE_NUM_EVENTS-1:0] wr_lane = unpack_word(strb_mask);
    wire [TMIE_NUM_EVENTS-1:0] wr_ones = unpack_word(wdata_r & strb_mask);

    // next enable state: direct overwrite, or write-one set / clear
    always_comb begin
        enable_nxt = enable_r;
        if (wr_go) begin
            case (wr_sel)
                TMIE_REG_DIRECT: enable_nxt = (enable_r & ~wr_lane) | wr_ones; // RULE_09
                // zeros leave bits alone since only ones are ored in or masked out
                TMIE_REG_SET: enable_nxt = enable_r | wr_ones; // RULE_01 RULE_03 RULE_04 RULE_05 RULE_10
                TMIE_REG_CLEAR: enable_nxt = enable_r & ~wr_ones; // RULE_02 RULE_06 RULE_07 RULE_08 RULE_10
                default: enable_nxt = enable_r;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // read path decode
    // ----------------------------------------------------------------
    wire ar_take = s_axi_arvalid_in && !rvalid_r;
    wire tmie_reg_t rd_sel = decode(s_axi_araddr_in);
    // all three mapped registers show the same enable state
    wire rd_hit = (rd_sel != TMIE_REG_NONE);
    wire [31:0] rd_word = rd_hit ? pack_word(enable_r) : TMIE_WORD_ZERO; // RULE_01 RULE_02 RULE_09

    // ----------------------------------------------------------------
    // enable register and interrupt
    // ----------------------------------------------------------------
    // enables come out of reset all off
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            enable_r <= TMIE_ENABLE_RESET; // RULE_10
            irq_r <= 1'b0;
        end else begin
            enable_r <= enable_nxt;
            // registered for a clean output; costs one cycle of latency
            irq_r <= |(event_pending_in & enable_r); // RULE_11
        end
    end

    // ----------------------------------------------------------------
    // write channel handshake
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            awaddr_r <= '0;
            wdata_r <= TMIE_WORD_ZERO;
            wstrb_r <= 4'h0;
        end else begin
            if (aw_take) begin
                aw_held_r <= 1'b1;
                awaddr_r <= s_axi_awaddr_in;
            end else if (wr_go) begin
                aw_held_r <= 1'b0;
            end
            if (w_take) begin
                w_held_r <= 1'b1;
                wdata_r <= s_axi_wdata_in;
                wstrb_r <= s_axi_wstrb_in;
            end else if (wr_go) begin
                w_held_r <= 1'b0;
            end
        end
    end

    // write response: slverr for an unmapped word
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            bvalid_r <= 1'b0;
            bresp_r <= TMIE_RESP_OKAY;
        end else if (wr_go) begin
            bvalid_r <= 1'b1;
            bresp_r <= (wr_sel == TMIE_REG_NONE) ? TMIE_RESP_SLVERR : TMIE_RESP_OKAY;
        end else if (s_axi_bready_in) begin
            bvalid_r <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // read channel handshake
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rvalid_r <= 1'b0;
            rdata_r <= TMIE_WORD_ZERO;
            rresp_r <= TMIE_RESP_OKAY;
        end else if (ar_take) begin
            rvalid_r <= 1'b1;
            rdata_r <= rd_word;
            rresp_r <= rd_hit ? TMIE_RESP_OKAY : TMIE_RESP_SLVERR;
        end else if (s_axi_rready_in) begin
            rvalid_r <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign s_axi_awready_out = !aw_held_r;
    assign s_axi_wready_out = !w_held_r;
    assign s_axi_bvalid_out = bvalid_r;
    assign s_axi_bresp_out = bresp_r;
    assign s_axi_arready_out = !rvalid_r;
    assign s_axi_rvalid_out = rvalid_r;
    assign s_axi_rdata_out = rdata_r;
    assign s_axi_rresp_out = rresp_r;
    assign irq_enable_out = enable_r;
    assign irq_out = irq_r;

endmodule

`default_nettype wire

// ### tb/tmie_irq_enable_monitor.sv
// concurrent checks on the ports of the interrupt-enable register block
`timescale 1ns/1ns
`default_nettype none
module tmie_irq_enable_monitor
    import tmie_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic rstn_in,
    // bus handshakes and answers
    input wire logic s_axi_awvalid_in,
    input wire logic s_axi_awready_out,
    input wire logic s_axi_wvalid_in,
    input wire logic s_axi_wready_out,
    input wire logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire logic [1:0] s_axi_bresp_out,
    input wire logic s_axi_arvalid_in,
    input wire logic s_axi_arready_out,
    input wire logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    input wire logic [31:0] s_axi_rdata_out,
    input wire logic [1:0] s_axi_rresp_out,
    // events, enables and interrupt
    input wire logic [6:0] event_pending_in,
    input wire logic [6:0] irq_enable_out,
    input wire logic irq_out
);
    // ----------------------------------------------------------------
    // one domain, so clock and reset are given once
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rstn_in);
    // enables placed at their field positions in a register word
    wire logic [31:0] pack_w = {7'h00, irq_enable_out[6:5], 2'h0, irq_enable_out[4:2], 8'h00,
        irq_enable_out[1], 7'h00, irq_enable_out[0], 1'b0};
    sequence s_aw_w;
        s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out;
    endsequence
    sequence s_ar_take;
        s_axi_arvalid_in && s_axi_arready_out;
    endsequence
    a_irq_follows_cause: assert property (irq_out == $past(|(event_pending_in & irq_enable_out)))
        else $error("interrupt level does not follow pending and enable");
    a_enable_at_commit: assert property ($changed(irq_enable_out) |-> $rose(s_axi_bvalid_out))
        else $error("enable state moved without a write response");
    a_bresp_holds: assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out && $stable(s_axi_bresp_out))
        else $error("write response dropped before bready");
    a_rdata_holds: assert property (s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
        else $error("read data dropped before rready");
    a_ar_gate: assert property (s_axi_arready_out == !s_axi_rvalid_out)
        else $error("read address ready not the inverse of rvalid");
    a_read_answer: assert property (s_ar_take |=> s_axi_rvalid_out)
        else $error("read answer late");
    a_write_answer: assert property (s_aw_w ##0 !s_axi_bvalid_out |-> ##[1:2] s_axi_bvalid_out)
        else $error("write answer late");
    a_read_data_match: assert property ($rose(s_axi_rvalid_out) && s_axi_rresp_out == TMIE_RESP_OKAY |-> s_axi_rdata_out == $past(pack_w))
        else $error("read data differs from enable state");
endmodule
bind tmie_irq_enable tmie_irq_enable_monitor u_mon (.clk_in, .rstn_in, .s_axi_awvalid_in, .s_axi_awready_out,
    .s_axi_wvalid_in, .s_axi_wready_out, .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_bresp_out, .s_axi_arvalid_in,
    .s_axi_arready_out, .s_axi_rvalid_out, .s_axi_rready_in, .s_axi_rdata_out, .s_axi_rresp_out,
    .event_pending_in, .irq_enable_out, .irq_out);
`default_nettype wire

// ### tb/two_wire_master_irq_enable_tb_top.sv
// self-checking bench for the interrupt-enable register block
`timescale 1ns/1ns
`default_nettype none
module two_wire_master_irq_enable_tb_top
    import tmie_pkg::*;
;
    // ----------------------------------------------------------------
    // stimulus, design and model
    // ----------------------------------------------------------------
    logic clk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic s_axi_awvalid_in = 1'b0, s_axi_wvalid_in = 1'b0, s_axi_bready_in = 1'b0;
    logic s_axi_arvalid_in = 1'b0, s_axi_rready_in = 1'b0;
    logic [11:0] s_axi_awaddr_in = 12'h000, s_axi_araddr_in = 12'h000;
    logic [31:0] s_axi_wdata_in = 32'h0000_0000;
    logic [3:0] s_axi_wstrb_in = 4'h0;
    logic [6:0] event_pending_in = 7'h00;
    wire logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out, irq_out;
    wire logic [1:0] s_axi_bresp_out, s_axi_rresp_out;
    wire logic [31:0] s_axi_rdata_out;
    wire logic [6:0] irq_enable_out;
    integer seed = 5, fails = 0, checks_done = 0, k;
    logic [6:0] en_m = 7'h00; // model of the enable state
    int bits[7] = '{1, 9, 18, 19, 20, 23, 24};
    tmie_irq_enable uut (.clk_in, .rstn_in, .s_axi_awvalid_in, .s_axi_awready_out, .s_axi_awaddr_in,
        .s_axi_wvalid_in, .s_axi_wready_out, .s_axi_wdata_in, .s_axi_wstrb_in, .s_axi_bvalid_out,
        .s_axi_bready_in, .s_axi_bresp_out, .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_araddr_in,
        .s_axi_rvalid_out, .s_axi_rready_in, .s_axi_rdata_out, .s_axi_rresp_out, .event_pending_in,
        .irq_enable_out, .irq_out);
    // 100 MHz clock
    initial forever #5 clk_in = ~clk_in;
    function automatic logic [6:0] fld(input logic [31:0] w);
        fld = {w[24], w[23], w[20], w[19], w[18], w[9], w[1]};
    endfunction
    function automatic logic [31:0] pk(input logic [6:0] e);
        pk = {7'h00, e[6:5], 2'h0, e[4:2], 8'h00, e[1], 7'h00, e[0], 1'b0};
    endfunction
    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // one write; the response is taken late at random so the hold logic is exercised
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        logic aw, w;
        logic [31:0] m;
        logic [1:0] r;
        aw = 1'b1;
        w = 1'b1;
        m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
        r = TMIE_RESP_OKAY;
        case (a)
            TMIE_OFS_DIRECT: en_m = fld(d & m) | (en_m & ~fld(m));
            TMIE_OFS_SET: en_m = en_m | fld(d & m);
            TMIE_OFS_CLEAR: en_m = en_m & ~fld(d & m);
            default: r = TMIE_RESP_SLVERR;
        endcase
        @(posedge clk_in);
        s_axi_awvalid_in <= 1'b1;
        s_axi_wvalid_in <= 1'b1;
        s_axi_awaddr_in <= a;
        s_axi_wdata_in <= d;
        s_axi_wstrb_in <= s;
        while (aw || w) begin
            @(posedge clk_in);
            if (aw && s_axi_awready_out === 1'b1) s_axi_awvalid_in <= 1'b0;
            if (w && s_axi_wready_out === 1'b1) s_axi_wvalid_in <= 1'b0;
            aw = aw && s_axi_awready_out !== 1'b1;
            w = w && s_axi_wready_out !== 1'b1;
        end
        repeat ($unsigned($random(seed)) % 3) @(posedge clk_in);
        s_axi_bready_in <= 1'b1;
        do @(posedge clk_in); while (s_axi_bvalid_out !== 1'b1);
        s_axi_bready_in <= 1'b0;
        chk("bresp", 32'(s_axi_bresp_out), 32'(r));
        chk("enables", 32'(irq_enable_out), 32'(en_m));
    endtask
    task automatic rd(input logic [11:0] a);
        logic h;
        h = a inside {TMIE_OFS_DIRECT, TMIE_OFS_SET, TMIE_OFS_CLEAR};
        @(posedge clk_in);
        s_axi_arvalid_in <= 1'b1;
        s_axi_araddr_in <= a;
        do @(posedge clk_in); while (s_axi_arready_out !== 1'b1);
        s_axi_arvalid_in <= 1'b0;
        repeat ($unsigned($random(seed)) % 3) @(posedge clk_in);
        s_axi_rready_in <= 1'b1;
        do @(posedge clk_in); while (s_axi_rvalid_out !== 1'b1);
        s_axi_rready_in <= 1'b0;
        chk("rdata", s_axi_rdata_out, h ? pk(en_m) : 32'h0000_0000);
        chk("rresp", 32'(s_axi_rresp_out), 32'(h ? TMIE_RESP_OKAY : TMIE_RESP_SLVERR));
    endtask
    // pending levels reach the interrupt one cycle after they are sampled
    task automatic pend(input logic [6:0] p);
        @(posedge clk_in);
        event_pending_in <= p;
        repeat (2) @(posedge clk_in);
        chk("irq", 32'(irq_out), 32'(|(p & en_m)));
    endtask
    initial begin
        repeat (12) @(posedge clk_in);
        rstn_in <= 1'b1;
        for (k = 0; k < 4; k++) rd(12'h300 + 12'(4 * k));
        // each event on its own: set, read through the clear view, clear again
        foreach (bits[i]) begin
            wr(TMIE_OFS_SET, 32'h0000_0001 << bits[i], 4'hf);
            rd(TMIE_OFS_CLEAR);
            pend(7'h7f);
            wr(TMIE_OFS_CLEAR, 32'h0000_0001 << bits[i], 4'hf);
            rd(TMIE_OFS_SET);
        end
        // random mix of all three views, the unmapped word and partial strobes
        for (k = 0; k < 40; k++) begin
            wr(12'h300 + 12'(4 * ($unsigned($random(seed)) % 4)), $random(seed), 4'($random(seed)));
            rd(12'h300 + 12'(4 * ($unsigned($random(seed)) % 4)));
            pend(7'($random(seed)));
        end
        // reset in mid-run with every enable on, so the cleared state is really exercised
        wr(TMIE_OFS_SET, 32'hffff_ffff, 4'hf);
        @(posedge clk_in);
        rstn_in <= 1'b0;
        en_m = 7'h00;
        repeat (3) @(posedge clk_in);
        rstn_in <= 1'b1;
        chk("enables after reset", 32'(irq_enable_out), 32'(en_m));
        rd(TMIE_OFS_DIRECT);
        pend(7'h7f);
        results;
    end
    // watchdog sized well past the several hundred cycles the sequence needs
    initial begin
        #100000;
        fails++;
        results;
    end
endmodule
`default_nettype wire
